// ---- hw/fcs_flash_timing_clock_gen.sv ----
// Flash timing clock generator: one bus-clock tick per timing period.
// Assumes divider inputs stay still once enable is high.
`timescale 1ns/1ps
module fcs_flash_timing_clock_gen
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic prescale8,
  input wire logic [FCS_DIV_W-1:0] div,
  output logic tick
);

  typedef struct packed {
    logic [FCS_DIV_W+2:0] cnt;
    logic tick;
  } fcs_gen_state_t;

  fcs_gen_state_t s;
  fcs_gen_state_t next_s;
  logic [FCS_DIV_W+2:0] period_m1;

  // Period is (div+1), times eight with the prescaler; see (R24).
  assign period_m1 = prescale8 ? {div, FCS_PRE8_LOW} : {3'h0, div};

  // Down counter; a tick is emitted as it wraps.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (enable) begin
      if (s.cnt == '0) begin
        next_s.cnt = period_m1;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  chk_tick_on_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    enable && s.cnt == '0 |=> tick) else $error("tick missing at wrap"); // see (R24)

endmodule

// ---- hw/fcs_pkg.sv ----
// Shared constants and types of the flash command sequencer.
// Assumes a 32-bit Avalon-MM register slave on a 125 MHz bus clock.
package fcs_pkg;

  // Bus clock rate in MHz, one period of 8 ns.
  localparam int FCS_CLK_MHZ = 125;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] FCS_OFS_DIVIDER = 5'h00;
  localparam logic [4:0] FCS_OFS_STATUS = 5'h04;
  localparam logic [4:0] FCS_OFS_COMMAND = 5'h08;
  localparam logic [4:0] FCS_OFS_ARRAY = 5'h0C;

  // Field positions of the divider register.
  localparam int FCS_DIV_LOADED_BIT = 7;
  localparam int FCS_DIV_PRE8_BIT = 6;
  localparam int FCS_DIV_W = 6;
  localparam logic [2:0] FCS_PRE8_LOW = 3'h7;

  // Field positions of the status register.
  localparam int FCS_STAT_CBEF_BIT = 7;
  localparam int FCS_STAT_CCF_BIT = 6;
  localparam int FCS_STAT_ACCERR_BIT = 4;

  // Field layout of the array write register: data low, address above.
  localparam int FCS_ARR_DATA_LSB = 0;
  localparam int FCS_ARR_ADDR_LSB = 8;
  localparam int FCS_ADDR_W = 14;
  localparam int FCS_CMD_W = 8;

  // Command codes.
  localparam logic [7:0] FCS_CMD_BLANK = 8'h05;
  localparam logic [7:0] FCS_CMD_PROG = 8'h20;
  localparam logic [7:0] FCS_CMD_BURST = 8'h25;
  localparam logic [7:0] FCS_CMD_PAGE = 8'h40;
  localparam logic [7:0] FCS_CMD_MASS = 8'h41;

  // Operation lengths in flash timing clock periods.
  localparam int FCS_PROG_FLASH_TIMING_CLOCK = 9;
  localparam int FCS_BURST_FLASH_TIMING_CLOCK = 4;
  localparam int FCS_PAGE_FLASH_TIMING_CLOCK = 4000;
  localparam int FCS_MASS_FLASH_TIMING_CLOCK = 20000;
  localparam int FCS_BLANK_FLASH_TIMING_CLOCK = 16;
  localparam int FCS_CNT_W = 15;

  // Array geometry.
  localparam int FCS_ARRAY_BYTES = 16384;
  localparam int FCS_PAGE_OFS_W = 9;
  localparam int FCS_ROW_OFS_W = 6;

  // Flag values after reset.
  localparam logic FCS_CBEF_RST = 1'b1;
  localparam logic FCS_CCF_RST = 1'b1;

  // Command sequence states.
  typedef enum logic [2:0] {
    FCS_EMPTY,
    FCS_HAVE_ADDR,
    FCS_HAVE_CMD,
    FCS_WAIT_TICK,
    FCS_RUN
  } fcs_seq_t;

  // Operation presented to the flash array while it executes.
  typedef struct packed {
    logic active;
    logic [FCS_CMD_W-1:0] cmd;
    logic [FCS_ADDR_W-1:0] addr;
    logic [7:0] data;
  } fcs_flash_op_t;

endpackage

// ---- hw/fcs_sequencer.sv ----
// Flash command sequencer: registers, command protocol and pulse timing.
// Assumes an Avalon-MM master on clk and a flash array that follows op.
// What the document requires
// (R01) Refuse commands until divider written after reset.
// (R02) Software keeps timing clock between 150-200 kHz.
// (R03) Divider register accepts one write only.
// (R04) Divider write ignored while access error set.
// (R05) Pulses timed in whole timing clock periods.
// (R06) Byte program 9 cycles, burst 4 cycles.
// (R07) Page erase 4000, mass erase 20000 cycles.
// (R08) Command starts with latched array write.
// (R09) Erase selects page; data ignored for erase.
// (R10) Codes 0x05, 0x20, 0x25: blank, program, burst.
// (R11) Codes 0x40, 0x41: page and mass erase.
// (R12) Writing one to buffer empty launches command.
// (R13) Writing zero aborts partial command, sets error.
// (R14) No new command while access error set.
// (R15) Complete flag shows command finished.
// (R16) Software never programs a byte twice.
// (R17) Erase always covers a whole 512-byte page.
// (R18) Array is 16384 or 8192 bytes of pages.
// (R19) Access error clears only by writing one.
// (R20) Invalid command code sets access error.
// (R21) Array write while buffer busy sets error.
// (R22) Stop mode aborts running command with error.
// (R23) Complete clears at launch; flags set at end.
// (R24) Timing clock is bus clock divided down.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int ARRAY_BYTES = FCS_ARRAY_BYTES,
  parameter int PAGE_CYCLES = FCS_PAGE_FLASH_TIMING_CLOCK,
  parameter int MASS_CYCLES = FCS_MASS_FLASH_TIMING_CLOCK,
  parameter int BLANK_CYCLES = FCS_BLANK_FLASH_TIMING_CLOCK
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stop_req,
  output fcs_flash_op_t flash_op
);

  typedef struct packed {
    fcs_seq_t seq;
    logic ack;
    logic [31:0] rdata;
    logic div_loaded;
    logic prescale8;
    logic [FCS_DIV_W-1:0] div;
    logic cbef;
    logic ccf;
    logic accerr;
    logic [FCS_CMD_W-1:0] cmd;
    logic [FCS_ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [FCS_CNT_W-1:0] count;
    logic last_burst;
    logic [FCS_ADDR_W-1:0] last_addr;
  } fcs_state_t;

  fcs_state_t s;
  fcs_state_t next_s;
  logic tick;
  logic req;
  logic wr;
  logic wr_div;
  logic wr_stat;
  logic wr_cmd;
  logic wr_arr;
  logic [FCS_ADDR_W-1:0] wr_addr;
  logic [FCS_CMD_W-1:0] wr_code;
  logic code_ok;
  logic partial;
  logic launch;
  logic burst_follow;
  logic running;
  logic [31:0] rd_value;
  logic [FCS_CNT_W-1:0] op_cycles;

  // Timing clock divider, started by the single divider load.
  fcs_flash_timing_clock_gen u_flash_timing_clock (
    .clk(clk),
    .rst_n(rst_n),
    .enable(s.div_loaded),
    .prescale8(s.prescale8),
    .div(s.div),
    .tick(tick)
  );

  // Bus handshake: each access waits one cycle, then completes.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~s.ack;
  assign avs_readdata = s.rdata;
  assign wr = avs_write & s.ack;
  assign wr_div = wr && avs_address == FCS_OFS_DIVIDER;
  assign wr_stat = wr && avs_address == FCS_OFS_STATUS;
  assign wr_cmd = wr && avs_address == FCS_OFS_COMMAND;
  assign wr_arr = wr && avs_address == FCS_OFS_ARRAY;
  assign wr_addr = avs_writedata[FCS_ARR_ADDR_LSB +: FCS_ADDR_W];
  assign wr_code = avs_writedata[FCS_CMD_W-1:0];
  assign partial = s.seq == FCS_HAVE_ADDR || s.seq == FCS_HAVE_CMD;
  assign running = s.seq == FCS_WAIT_TICK || s.seq == FCS_RUN;
  assign launch = wr_stat && avs_writedata[FCS_STAT_CBEF_BIT]
    && s.seq == FCS_HAVE_CMD && !s.accerr;

  // Only the five documented codes are accepted; see (R10) (R11).
  assign code_ok = wr_code == FCS_CMD_BLANK || wr_code == FCS_CMD_PROG
    || wr_code == FCS_CMD_BURST || wr_code == FCS_CMD_PAGE
    || wr_code == FCS_CMD_MASS;

  // A burst byte runs short only when it continues the previous byte
  // on the same row; a row start pays the full pump overhead.
  assign burst_follow = s.last_burst
    && s.addr == s.last_addr + 1'b1
    && s.addr[FCS_ROW_OFS_W-1:0] != '0;

  // Operation length in timing clock periods; see (R06) (R07).
  always_comb begin
    op_cycles = FCS_CNT_W'(BLANK_CYCLES);
    case (s.cmd)
      FCS_CMD_PROG: op_cycles = FCS_CNT_W'(FCS_PROG_FLASH_TIMING_CLOCK);
      FCS_CMD_BURST: begin
        op_cycles = burst_follow ? FCS_CNT_W'(FCS_BURST_FLASH_TIMING_CLOCK)
          : FCS_CNT_W'(FCS_PROG_FLASH_TIMING_CLOCK);
      end
      FCS_CMD_PAGE: op_cycles = FCS_CNT_W'(PAGE_CYCLES);
      FCS_CMD_MASS: op_cycles = FCS_CNT_W'(MASS_CYCLES);
      default: op_cycles = FCS_CNT_W'(BLANK_CYCLES);
    endcase
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rd_value = '0;
    if (avs_address == FCS_OFS_DIVIDER) begin
      rd_value[FCS_DIV_LOADED_BIT] = s.div_loaded;
      rd_value[FCS_DIV_PRE8_BIT] = s.prescale8;
      rd_value[FCS_DIV_W-1:0] = s.div;
    end else if (avs_address == FCS_OFS_STATUS) begin
      rd_value[FCS_STAT_CBEF_BIT] = s.cbef;
      rd_value[FCS_STAT_CCF_BIT] = s.ccf;
      rd_value[FCS_STAT_ACCERR_BIT] = s.accerr;
    end else if (avs_address == FCS_OFS_COMMAND) begin
      rd_value[FCS_CMD_W-1:0] = s.cmd;
    end else if (avs_address == FCS_OFS_ARRAY) begin
      rd_value[FCS_ARR_ADDR_LSB +: FCS_ADDR_W] = s.addr;
      rd_value[FCS_ARR_DATA_LSB +: 8] = s.data;
    end
  end

  // Next state. Error sets are gathered first so a set in the same
  // cycle as a software clear still wins.
  always_comb begin
    logic set_err;
    logic clr_err;
    set_err = 1'b0;
    clr_err = 1'b0;
    next_s = s;
    next_s.ack = req & ~s.ack;
    if (req && !s.ack) begin
      next_s.rdata = rd_value;
    end
    // The divider loads once, and never over a pending error.
    if (wr_div && !s.div_loaded && !s.accerr) begin // see (R03) (R04)
      next_s.div_loaded = 1'b1;
      next_s.prescale8 = avs_writedata[FCS_DIV_PRE8_BIT];
      next_s.div = avs_writedata[FCS_DIV_W-1:0];
    end
    // First step: the array write latches address and data.
    if (wr_arr && !s.accerr) begin // see (R14)
      if (!s.div_loaded) begin
        set_err = 1'b1; // see (R01)
      end else if (!s.cbef || s.seq != FCS_EMPTY) begin
        set_err = 1'b1; // see (R21)
      end else if (32'(wr_addr) >= 32'(ARRAY_BYTES)) begin
        set_err = 1'b1; // see (R18)
      end else begin
        next_s.addr = wr_addr; // see (R08)
        next_s.data = avs_writedata[FCS_ARR_DATA_LSB +: 8];
        next_s.seq = FCS_HAVE_ADDR;
      end
    end
    // Second step: exactly one code after the array write.
    if (wr_cmd && !s.accerr) begin
      if (s.seq == FCS_HAVE_ADDR && code_ok) begin
        next_s.cmd = wr_code; // see (R10) (R11)
        next_s.seq = FCS_HAVE_CMD;
      end else begin
        set_err = 1'b1; // see (R20)
      end
    end
    // Status write: one clears the error, cbef launches or aborts.
    if (wr_stat) begin
      clr_err = avs_writedata[FCS_STAT_ACCERR_BIT]; // see (R19)
      if (launch) begin
        next_s.cbef = 1'b0; // see (R12)
        next_s.ccf = 1'b0; // see (R23)
        next_s.count = op_cycles;
        next_s.seq = FCS_WAIT_TICK;
      end else if (!avs_writedata[FCS_STAT_CBEF_BIT] && partial) begin
        set_err = 1'b1; // see (R13)
      end
    end
    // Execution runs on timing clock ticks only; see (R05).
    case (s.seq)
      FCS_WAIT_TICK: begin
        if (tick) begin
          next_s.seq = FCS_RUN;
        end
      end
      FCS_RUN: begin
        if (tick) begin
          next_s.count = s.count - 1'b1;
          if (s.count == FCS_CNT_W'(1)) begin
            next_s.seq = FCS_EMPTY;
            next_s.cbef = 1'b1; // see (R23)
            next_s.ccf = 1'b1; // see (R15)
            next_s.last_burst = s.cmd == FCS_CMD_BURST;
            next_s.last_addr = s.addr;
          end
        end
      end
      default: begin
      end
    endcase
    // Stop mode kills a running operation and reports it.
    if (stop_req && running) begin // see (R22)
      set_err = 1'b1;
      next_s.seq = FCS_EMPTY;
      next_s.cbef = 1'b1;
      next_s.ccf = 1'b1;
      next_s.last_burst = 1'b0;
    end
    // Any error drops a partial command.
    if (set_err && partial && !launch) begin
      next_s.seq = FCS_EMPTY;
    end
    next_s.accerr = set_err | (s.accerr & ~clr_err);
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.seq <= FCS_EMPTY;
      s.cbef <= FCS_CBEF_RST;
      s.ccf <= FCS_CCF_RST;
    end else begin
      s <= next_s;
    end
  end

  // Array view. Erase forms a page-aligned address and zero data,
  // mass erase a zero address, so no partial page is touched.
  always_comb begin
    flash_op.active = s.seq == FCS_RUN;
    flash_op.cmd = s.cmd;
    flash_op.addr = s.addr;
    flash_op.data = s.data;
    if (s.cmd == FCS_CMD_PAGE) begin // see (R09) (R17)
      flash_op.addr[FCS_PAGE_OFS_W-1:0] = '0;
      flash_op.data = '0;
    end else if (s.cmd == FCS_CMD_MASS || s.cmd == FCS_CMD_BLANK) begin
      flash_op.addr = '0;
      flash_op.data = '0;
    end
  end

  chk_div_once: assert property (@(posedge clk) disable iff (!rst_n)
    s.div_loaded && wr_div |=> $stable(s.div) && $stable(s.prescale8))
    else $error("divider changed after first load"); // see (R03)

  chk_div_err_block: assert property (@(posedge clk) disable iff (!rst_n)
    !s.div_loaded && s.accerr && wr_div |=> !s.div_loaded)
    else $error("divider loaded over access error"); // see (R04)

  chk_no_div_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    wr_arr && !s.div_loaded && !s.accerr |=> s.accerr && s.seq == FCS_EMPTY)
    else $error("array write before divider accepted"); // see (R01)

  chk_err_no_start: assert property (@(posedge clk) disable iff (!rst_n)
    s.accerr && s.seq != FCS_WAIT_TICK |=> s.seq != FCS_WAIT_TICK)
    else $error("command started with access error set"); // see (R14)

  chk_bad_code_err: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cmd && !code_ok && !s.accerr |=> s.accerr && s.seq == FCS_EMPTY)
    else $error("invalid code not flagged"); // see (R20)

  chk_busy_array_err: assert property (@(posedge clk) disable iff (!rst_n)
    wr_arr && !s.cbef && !s.accerr |=> s.accerr)
    else $error("array write with busy buffer not flagged"); // see (R21)

  chk_abort_err: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stat && !avs_writedata[FCS_STAT_CBEF_BIT] && partial
    |=> s.accerr && s.seq == FCS_EMPTY)
    else $error("abort did not flag error"); // see (R13)

  chk_launch_flags: assert property (@(posedge clk) disable iff (!rst_n)
    launch && !stop_req |=> !s.cbef && !s.ccf && s.seq == FCS_WAIT_TICK)
    else $error("launch flags wrong"); // see (R12)

  chk_done_flags: assert property (@(posedge clk) disable iff (!rst_n)
    s.seq == FCS_RUN && tick && s.count == FCS_CNT_W'(1) && !stop_req
    |=> s.ccf && s.cbef && !flash_op.active)
    else $error("completion flags not set"); // see (R15) (R23)

  chk_tick_count: assert property (@(posedge clk) disable iff (!rst_n)
    s.seq == FCS_RUN && !tick && !stop_req |=> $stable(s.count))
    else $error("count moved without timing tick"); // see (R05)

  chk_stop_abort: assert property (@(posedge clk) disable iff (!rst_n)
    stop_req && running |=> s.accerr && s.cbef && !flash_op.active)
    else $error("stop did not abort command"); // see (R22)

  chk_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s.accerr && !(wr_stat && avs_writedata[FCS_STAT_ACCERR_BIT]) |=> s.accerr)
    else $error("access error cleared without write"); // see (R19)

  chk_page_align: assert property (@(posedge clk) disable iff (!rst_n)
    flash_op.active && flash_op.cmd == FCS_CMD_PAGE
    |-> flash_op.addr[FCS_PAGE_OFS_W-1:0] == '0 && flash_op.data == '0)
    else $error("page erase address not aligned"); // see (R17)

  chk_prog_length: assert property (@(posedge clk) disable iff (!rst_n)
    launch && s.cmd == FCS_CMD_PROG |=> s.count == FCS_CNT_W'(FCS_PROG_FLASH_TIMING_CLOCK))
    else $error("byte program length wrong"); // see (R06)

  chk_burst_length: assert property (@(posedge clk) disable iff (!rst_n)
    launch && s.cmd == FCS_CMD_BURST && burst_follow
    |=> s.count == FCS_CNT_W'(FCS_BURST_FLASH_TIMING_CLOCK))
    else $error("burst byte length wrong"); // see (R06)

  chk_page_length: assert property (@(posedge clk) disable iff (!rst_n)
    launch && s.cmd == FCS_CMD_PAGE |=> s.count == FCS_CNT_W'(PAGE_CYCLES))
    else $error("page erase length wrong"); // see (R07)

  chk_mass_length: assert property (@(posedge clk) disable iff (!rst_n)
    launch && s.cmd == FCS_CMD_MASS |=> s.count == FCS_CNT_W'(MASS_CYCLES))
    else $error("mass erase length wrong"); // see (R07)

  // An address past the array end must never start a command.
  chk_range_err: assert property (@(posedge clk) disable iff (!rst_n)
    wr_arr && s.div_loaded && s.cbef && s.seq == FCS_EMPTY && !s.accerr
    && 32'(wr_addr) >= 32'(ARRAY_BYTES) |=> s.accerr && s.seq == FCS_EMPTY)
    else $error("out of range array write not flagged"); // see (R18)

endmodule

// ---- tb/fcs_flash_model.sv ----
// Behavioural model of the flash array and charge pump behind the sequencer.
// Assumes flash_op holds its command, address and data while active is high.
`timescale 1ns/1ps
module fcs_flash_model
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire fcs_flash_op_t flash_op,
  output int op_count,
  output int last_len,
  output fcs_flash_op_t last_op,
  output int reprog_err
);
  logic [7:0] mem [FCS_ARRAY_BYTES];
  int run;
  fcs_flash_op_t cur;

  // Apply a finished operation to the array contents.
  task automatic apply(input fcs_flash_op_t op);
    case (op.cmd)
      FCS_CMD_PROG, FCS_CMD_BURST: begin
        if (mem[op.addr] !== 8'hFF) reprog_err <= reprog_err + 1;
        mem[op.addr] = mem[op.addr] & op.data;
      end
      FCS_CMD_PAGE: begin
        // A whole page is wiped, never a part of one.
        for (int i = 0; i < 512; i++) begin
          mem[{op.addr[13:9], 9'h000} + i] = 8'hFF;
        end
      end
      FCS_CMD_MASS: begin
        foreach (mem[i]) mem[i] = 8'hFF;
      end
      default: begin
      end
    endcase
  endtask

  // The array starts erased, as after a mass erase.
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end

  // Time each operation in bus cycles and apply it when active drops.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 0;
      op_count <= 0;
      last_len <= 0;
      last_op <= '0;
      reprog_err <= 0;
      cur <= '0;
    end else if (flash_op.active) begin
      if (run == 0) cur <= flash_op;
      run <= run + 1;
    end else if (run != 0) begin
      run <= 0;
      last_len <= run;
      last_op <= cur;
      op_count <= op_count + 1;
      apply(cur);
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the flash command sequencer with an array model.
// Assumes the Avalon-MM slave answers every request after a wait cycle.
`timescale 1ns/1ps
module tb
  import fcs_pkg::*;
;
  localparam int PAGE_N = 5;
  localparam int MASS_N = 7;
  localparam int ARR_N = 8192;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic stop_req = 1'b0;
  fcs_flash_op_t flash_op;
  fcs_flash_op_t last_op;
  int op_count, last_len, reprog_err, per, n;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'd97294;
  logic [31:0] rd, r;
  logic [13:0] a, base;
  logic [7:0] codes [6] = '{FCS_CMD_BLANK, FCS_CMD_PROG, FCS_CMD_BURST,
    FCS_CMD_BURST, FCS_CMD_PAGE, FCS_CMD_MASS};
  int lens [6] = '{FCS_BLANK_FLASH_TIMING_CLOCK, FCS_PROG_FLASH_TIMING_CLOCK, FCS_PROG_FLASH_TIMING_CLOCK,
    FCS_BURST_FLASH_TIMING_CLOCK, PAGE_N, MASS_N};
  logic [13:0] ofs [6] = '{14'h0, 14'h8, 14'h0, 14'h1, 14'h3, 14'h0};

  // Short erase counts keep the run brief; the smaller array variant
  // leaves addresses past its end for the range check.
  fcs_sequencer #(
    .ARRAY_BYTES(ARR_N), .PAGE_CYCLES(PAGE_N), .MASS_CYCLES(MASS_N)
  ) u_fcs_sequencer (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_req(stop_req),
    .flash_op(flash_op));

  fcs_flash_model u_fcs_flash_model (
    .clk(clk), .rst_n(rst_n), .flash_op(flash_op), .op_count(op_count),
    .last_len(last_len), .last_op(last_op), .reprog_err(reprog_err));

  // Bus clock of 125 MHz.
  always #4 clk = ~clk;

  // Repeatable xorshift source.
  function automatic logic [31:0] next_rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Operation the array should see: erases ignore data and low address bits.
  function automatic fcs_flash_op_t exp_op(input logic [7:0] c,
    input logic [13:0] ad, input logic [7:0] d);
    fcs_flash_op_t o;
    o = '{active: 1'b1, cmd: c, addr: 14'h0, data: 8'h00};
    if (c == FCS_CMD_PROG || c == FCS_CMD_BURST) begin
      o.addr = ad;
      o.data = d;
    end else if (c == FCS_CMD_PAGE) begin
      o.addr = {ad[13:9], 9'h000};
    end
    return o;
  endfunction

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // One bus access; waitrequest is sampled just before each rising edge.
  task automatic bus(input logic wr, input logic [4:0] ad,
    input logic [31:0] d);
    int k;
    logic w;
    k = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(negedge clk);
      w = avs_waitrequest;
      rd = avs_readdata;
      @(posedge clk);
      k++;
    end while (w !== 1'b0 && k < 20);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (w !== 1'b0) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge clk);
  endtask

  task automatic stat(input logic [7:0] e);
    bus(1'b0, FCS_OFS_STATUS, 32'h0);
    chk("status", {24'h0, e}, {24'h0, rd[7:0] & 8'hD0});
  endtask

  task automatic cmd(input logic [7:0] c, input logic [13:0] ad,
    input logic [7:0] d);
    bus(1'b1, FCS_OFS_ARRAY, {10'h0, ad, d});
    bus(1'b1, FCS_OFS_COMMAND, {24'h0, c});
    bus(1'b1, FCS_OFS_STATUS, 32'h80);
  endtask

  // Polls the complete flag under a bound; running out ends the run.
  task automatic wait_ccf();
    int k;
    k = 0;
    do begin
      bus(1'b0, FCS_OFS_STATUS, 32'h0);
      k++;
    end while (rd[FCS_STAT_CCF_BIT] !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    stat(8'hC0);
    bus(1'b1, 5'h14, 32'hFF);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    cmd(FCS_CMD_PROG, 14'h0100, 8'h55);
    stat(8'hD0);
    chk("refused count", 32'h0, op_count);
    bus(1'b1, FCS_OFS_DIVIDER, 32'h01);
    bus(1'b0, FCS_OFS_DIVIDER, 32'h0);
    chk("divider locked", 32'h0, {24'h0, rd[7:0]});
    bus(1'b1, FCS_OFS_STATUS, 32'h00);
    stat(8'hD0);
    bus(1'b1, FCS_OFS_STATUS, 32'h10);
    stat(8'hC0);
    // Random divider, small enough for a short run; the legal timing
    // clock range is traded here for simulation time.
    r = next_rnd();
    per = (r[2:0] + 1) * (r[6] ? 8 : 1);
    bus(1'b1, FCS_OFS_DIVIDER, {25'h0, r[6], 3'h0, r[2:0]});
    bus(1'b1, FCS_OFS_DIVIDER, {25'h0, !r[6], 6'h3F});
    bus(1'b0, FCS_OFS_DIVIDER, 32'h0);
    chk("divider", {24'h0, 1'b1, r[6], 3'h0, r[2:0]}, {24'h0, rd[7:0]});
    r = next_rnd();
    base = {1'b0, r[12:6], 6'h10};
    // Every code once and burst twice; the second burst follows on the next address.
    for (int i = 0; i < 6; i++) begin
      r = next_rnd();
      a = (ofs[i] == 14'h0 && i != 2) ? {1'b0, r[20:8]} : base + ofs[i];
      cmd(codes[i], a, r[7:0]);
      if (lens[i] > 4) stat(8'h00);
      wait_ccf();
      stat(8'hC0);
      chk("length", 32'h1, 32'(last_len >= lens[i] * per - 1 && last_len <= (lens[i] + 1) * per));
      chk("array op", {1'b0, exp_op(codes[i], a, r[7:0])}, {1'b0, last_op});
    end
    cmd(FCS_CMD_PAGE, base, 8'h00);
    bus(1'b1, FCS_OFS_ARRAY, 32'h0);
    wait_ccf();
    stat(8'hD0);
    bus(1'b1, FCS_OFS_STATUS, 32'h10);
    r = next_rnd();
    bus(1'b1, FCS_OFS_ARRAY, {10'h0, base, 8'h0});
    bus(1'b1, FCS_OFS_COMMAND, {24'h0, r[7:0] | 8'h80});
    stat(8'hD0);
    bus(1'b1, FCS_OFS_STATUS, 32'h10);
    bus(1'b1, FCS_OFS_ARRAY, {10'h0, base, 8'h0});
    bus(1'b1, FCS_OFS_STATUS, 32'h00);
    stat(8'hD0);
    n = op_count;
    cmd(FCS_CMD_PROG, base + 14'd20, 8'h0F);
    stat(8'hD0);
    chk("blocked count", n, op_count);
    bus(1'b1, FCS_OFS_STATUS, 32'h10);
    // First address past the end of the smaller array.
    bus(1'b1, FCS_OFS_ARRAY, {10'h0, 14'(ARR_N), 8'h0});
    stat(8'hD0);
    bus(1'b1, FCS_OFS_STATUS, 32'h10);
    // Stop mode in the middle of a mass erase.
    cmd(FCS_CMD_MASS, 14'h0, 8'h00);
    n = 0;
    while (flash_op.active !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (flash_op.active !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    @(negedge clk);
    chk("active after stop", 32'h0, {31'h0, flash_op.active});
    @(posedge clk);
    stat(8'hD0);
    chk("reprogram", 32'h0, reprog_err);
    stop_test();
  end
endmodule
